// ### shared/exec_pkg.sv
// Package: opcodes, flag positions, reset values and carriers for the execution block
package exec_pkg;
    localparam int          DATA_W         = 8;
    localparam int          ADDR_W         = 7;
    localparam int          WDT_W          = 8;
    localparam int          PRE_W          = 8;
    localparam int          NIB_MSB        = 3;
    localparam logic [7:0]  ACC_RESET      = 8'h00;
    localparam logic [7:0]  WDT_CLEAR      = 8'h00;
    localparam logic [7:0]  PRE_CLEAR      = 8'h00;
    localparam logic        DEST_ACC       = 1'b0;
    localparam logic        DEST_FILE      = 1'b1;
    localparam logic        CARRY_RESET    = 1'b0;
    localparam logic        NIBBLE_RESET   = 1'b0;
    localparam logic        ZERO_RESET     = 1'b0;
    localparam logic        EXPIRY_RESET   = 1'b1;
    localparam logic        LOWPWR_RESET   = 1'b1;

    typedef enum logic [2:0] {
        OP_NONE                        = 3'h0,
        OP_ROTATE_RIGHT_VIA_CARRY      = 3'h1,
        OP_LITERAL_MINUS_ACC           = 3'h2,
        OP_FILE_MINUS_ACC              = 3'h3,
        OP_FILE_MINUS_ACC_WITH_BORROW  = 3'h4,
        OP_SLEEP                       = 3'h5
    } op_t;

    typedef struct packed {
        op_t                 op;
        logic                dest;
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   literal;
        logic [DATA_W-1:0]   file_value;
    } instr_t;

    typedef struct packed {
        logic carry;
        logic nibble_borrow_flag;
        logic zero;
        logic expiry_status;
        logic low_power_status;
    } status_t;

    typedef struct packed {
        logic                we;
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   data;
    } file_wr_t;
endpackage

// ### rtl/sub_unit.sv
// Subtractor: a - b - (not carry_in) with borrow-style carry, nibble carry and zero
`timescale 1ns/1ps
module sub_unit
    import exec_pkg::*;
#(
    parameter int WIDTH = DATA_W
) (
    // Operands
    input  wire logic [WIDTH-1:0] a,
    input  wire logic [WIDTH-1:0] b,
    input  wire logic             carry_in,
    // Result
    output logic      [WIDTH-1:0] diff,
    output logic                  carry_out,
    output logic                  nibble_out,
    output logic                  zero_out
);
    // The nibble borrow needs at least one bit above the low nibble
    if (WIDTH < NIB_MSB + 2) begin : g_width_check
        $error("sub_unit: WIDTH too small");
    end

    logic [WIDTH:0]   full;
    logic [NIB_MSB+1:0] low;

    // a + ~b + cin: carry out is 1 when no borrow occurred
    always_comb begin
        full       = {1'b0, a} + {1'b0, ~b} + {{WIDTH{1'b0}}, carry_in};
        low        = {1'b0, a[NIB_MSB:0]} + {1'b0, ~b[NIB_MSB:0]}
                   + {{(NIB_MSB+1){1'b0}}, carry_in};
        diff       = full[WIDTH-1:0];
        carry_out  = full[WIDTH];
        nibble_out = low[NIB_MSB+1];
        zero_out   = (full[WIDTH-1:0] == '0); // RL11
    end
endmodule

// ### rtl/rotate_subtract_sleep_ops.sv
// Execution of rotate-right, three subtractions and sleep, with status and watchdog effects
// Contract
// RL1 - Rotate right: old carry into bit 7, old bit 0 into carry only.
// RL2 - Rotate result goes to accumulator on select 0, file on 1.
// RL3 - Literal minus accumulator, two's complement, result into accumulator.
// RL4 - Carry 0 if accumulator exceeds literal; nibble flag likewise on low nibbles.
// RL5 - File minus accumulator, result to accumulator on 0, file on 1.
// RL6 - Carry 0 if accumulator exceeds file; nibble flag likewise on low nibbles.
// RL7 - File minus accumulator minus inverted borrow, routed by select, flags updated.
// RL8 - Sleep clears watchdog counter and its prescaler.
// RL9 - Sleep clears low-power status, sets expiry status, nothing else changes.
// RL10 - Sleep halts oscillator and stops instruction execution.
// RL11 - Subtractions set zero flag when 8-bit result is zero.
`timescale 1ns/1ps
module rotate_subtract_sleep_ops
    import exec_pkg::*;
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              reset_n,
    // Instruction issue
    input  wire logic              instr_valid,
    input  wire instr_t            instr,
    // Wake from sleep (from same-clock wake logic)
    input  wire logic              wake,
    // Watchdog tick from the core's own timebase
    input  wire logic              wdt_tick,
    // Architectural state
    output logic      [DATA_W-1:0] acc,
    output status_t                status,
    output file_wr_t               file_wr,
    // Watchdog
    output logic      [WDT_W-1:0]  watchdog_counter,
    output logic      [PRE_W-1:0]  wdt_prescaler,
    // Power state
    output logic                   sleeping,
    output logic                   osc_run,
    output logic                   instr_ready
);
    logic [DATA_W-1:0] next_acc;
    status_t           next_status;
    file_wr_t          next_file_wr;
    logic [WDT_W-1:0]  next_watchdog_counter;
    logic [PRE_W-1:0]  next_wdt_prescaler;
    logic              next_sleeping;

    logic [DATA_W-1:0] sub_a;
    logic              sub_cin;
    logic [DATA_W-1:0] sub_diff;
    logic              sub_carry;
    logic              sub_nibble;
    logic              sub_zero;
    logic [DATA_W-1:0] rot;
    logic              exec;
    logic              sleep_go;

    // Execution is accepted only while awake
    assign instr_ready = ~sleeping; // RL10
    assign osc_run     = ~sleeping; // RL10
    assign exec        = instr_valid & ~sleeping; // RL10
    assign sleep_go    = exec & (instr.op == OP_SLEEP); // RL10

    // Operand select: literal or file minuend; borrow only for the borrow form
    always_comb begin
        sub_a   = (instr.op == OP_LITERAL_MINUS_ACC) ? instr.literal : instr.file_value;
        sub_cin = (instr.op == OP_FILE_MINUS_ACC_WITH_BORROW) ? status.carry : 1'b1; // RL7
        rot     = {status.carry, instr.file_value[DATA_W-1:1]}; // RL1
    end

    sub_unit #(
        .WIDTH (DATA_W)
    ) u_sub (
        .a          (sub_a),
        .b          (acc),
        .carry_in   (sub_cin),
        .diff       (sub_diff),
        .carry_out  (sub_carry),
        .nibble_out (sub_nibble),
        .zero_out   (sub_zero)
    );

    // Accumulator, status flags and file write-back
    always_comb begin
        next_acc          = acc;
        next_status       = status;
        next_file_wr      = '0;
        next_file_wr.addr = instr.addr;
        if (exec) begin
            unique case (instr.op)
                OP_ROTATE_RIGHT_VIA_CARRY: begin
                    next_status.carry = instr.file_value[0]; // RL1
                    if (instr.dest == DEST_ACC) begin
                        next_acc = rot; // RL2
                    end else begin
                        next_file_wr.we   = 1'b1; // RL2
                        next_file_wr.data = rot;
                    end
                end
                OP_LITERAL_MINUS_ACC: begin
                    next_acc                       = sub_diff; // RL3
                    next_status.carry              = sub_carry; // RL4
                    next_status.nibble_borrow_flag = sub_nibble; // RL4
                    next_status.zero               = sub_zero; // RL11
                end
                OP_FILE_MINUS_ACC: begin
                    // Carry and nibble are no-borrow bits: 1 unless acc exceeds file
                    next_status.carry              = sub_carry; // RL6
                    next_status.nibble_borrow_flag = sub_nibble; // RL6
                    next_status.zero               = sub_zero; // RL11
                    if (instr.dest == DEST_ACC) begin
                        next_acc = sub_diff; // RL5
                    end else begin
                        next_file_wr.we   = 1'b1; // RL5
                        next_file_wr.data = sub_diff; // RL5
                    end
                end
                OP_FILE_MINUS_ACC_WITH_BORROW: begin
                    // Same subtractor with the old carry as carry-in, so the
                    // nibble flag also sees the incoming borrow
                    next_status.carry              = sub_carry; // RL7
                    next_status.nibble_borrow_flag = sub_nibble; // RL7
                    next_status.zero               = sub_zero; // RL11
                    if (instr.dest == DEST_ACC) begin
                        next_acc = sub_diff; // RL7
                    end else begin
                        next_file_wr.we   = 1'b1; // RL7
                        next_file_wr.data = sub_diff; // RL7
                    end
                end
                OP_SLEEP: begin
                    // Only the two power status bits move; the rest keep their value
                    next_status.expiry_status    = 1'b1; // RL9
                    next_status.low_power_status = 1'b0; // RL9
                end
                OP_NONE: begin
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            acc                       <= ACC_RESET;
            status.carry              <= CARRY_RESET;
            status.nibble_borrow_flag <= NIBBLE_RESET;
            status.zero               <= ZERO_RESET;
            status.expiry_status      <= EXPIRY_RESET;
            status.low_power_status   <= LOWPWR_RESET;
            file_wr                   <= '0;
        end else begin
            acc     <= next_acc;
            status  <= next_status;
            file_wr <= next_file_wr;
        end
    end

    // Watchdog counter and prescaler
    always_comb begin
        next_watchdog_counter = watchdog_counter;
        next_wdt_prescaler    = wdt_prescaler;
        if (sleep_go) begin
            next_watchdog_counter = WDT_CLEAR; // RL8
            next_wdt_prescaler    = PRE_CLEAR; // RL8
        end else if (!sleeping) begin
            // Both stand still while asleep: a sleeping watchdog would need
            // its own oscillator, which this block does not model
            next_wdt_prescaler = wdt_prescaler + PRE_W'(1);
            if (wdt_tick) begin
                next_watchdog_counter = watchdog_counter + WDT_W'(1);
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            watchdog_counter <= WDT_CLEAR;
            wdt_prescaler    <= PRE_CLEAR;
        end else begin
            watchdog_counter <= next_watchdog_counter;
            wdt_prescaler    <= next_wdt_prescaler;
        end
    end

    // Sleep state; wake is looked at only while asleep
    always_comb begin
        next_sleeping = sleeping;
        if (sleep_go) begin
            next_sleeping = 1'b1; // RL10
        end else if (sleeping && wake) begin
            next_sleeping = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sleeping <= 1'b0;
        end else begin
            sleeping <= next_sleeping;
        end
    end
endmodule

// ### test/rotate_subtract_sleep_ops_chk.sv
// Checker for the rotate, subtract and sleep execution block
`timescale 1ns/1ps
module rotate_subtract_sleep_ops_chk
    import exec_pkg::*;
(
    // Clock and reset
    input wire logic              clk,
    input wire logic              reset_n,
    // Inputs
    input wire logic              instr_valid,
    input wire instr_t            instr,
    input wire logic              wake,
    input wire logic              wdt_tick,
    // Outputs
    input wire logic [DATA_W-1:0] acc,
    input wire status_t           status,
    input wire file_wr_t          file_wr,
    input wire logic [WDT_W-1:0]  watchdog_counter,
    input wire logic [PRE_W-1:0]  wdt_prescaler,
    input wire logic              sleeping,
    input wire logic              osc_run,
    input wire logic              instr_ready
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    // Operands seen at the issue edge, kept for the next cycle
    instr_t            p_in;
    logic [DATA_W-1:0] p_acc;
    logic              p_c;
    wire               go = instr_valid && instr_ready;
    always_ff @(posedge clk) begin
        p_in  <= instr;
        p_acc <= acc;
        p_c   <= status.carry;
    end
    rot_carry_a: assert property (go && instr.op == OP_ROTATE_RIGHT_VIA_CARRY
        |=> status.carry == p_in.file_value[0]) else $error("rotate carry wrong");
    rot_acc_a: assert property (go && instr.op == OP_ROTATE_RIGHT_VIA_CARRY && !instr.dest
        |=> acc == {p_c, p_in.file_value[7:1]}) else $error("rotate result wrong");
    lit_sub_a: assert property (go && instr.op == OP_LITERAL_MINUS_ACC
        |=> acc == p_in.literal - p_acc && status.carry == (p_acc <= p_in.literal)
        && status.nibble_borrow_flag == (p_acc[3:0] <= p_in.literal[3:0]))
        else $error("literal subtract wrong");
    file_sub_a: assert property (go && instr.op == OP_FILE_MINUS_ACC && instr.dest
        |=> file_wr.we && file_wr.data == p_in.file_value - p_acc && acc == p_acc)
        else $error("file subtract write wrong");
    file_nib_a: assert property (go && instr.op == OP_FILE_MINUS_ACC
        |=> status.nibble_borrow_flag == (p_acc[3:0] <= p_in.file_value[3:0]))
        else $error("nibble flag wrong");
    borrow_acc_a: assert property (go && instr.op == OP_FILE_MINUS_ACC_WITH_BORROW && !instr.dest
        |=> acc == p_in.file_value - p_acc - {7'h0, !p_c}) else $error("borrow subtract wrong");
    zero_flag_a: assert property (go && instr.op inside {[3'h2:3'h4]}
        |=> status.zero == ((p_in.dest && p_in.op != OP_LITERAL_MINUS_ACC)
        ? file_wr.data == 8'h00 : acc == 8'h00))
        else $error("zero flag wrong");
    sleep_clr_a: assert property (go && instr.op == OP_SLEEP
        |=> watchdog_counter == WDT_CLEAR && wdt_prescaler == PRE_CLEAR
        && !status.low_power_status && status.expiry_status && status.carry == p_c)
        else $error("sleep side effects wrong");
    halt_run_a: assert property (sleeping |-> !osc_run && !instr_ready)
        else $error("running while asleep");
    cover property (go && instr.op == OP_SLEEP);
    cover property (go && instr.op == OP_FILE_MINUS_ACC_WITH_BORROW);
    cover property (sleeping && wake);
endmodule
bind rotate_subtract_sleep_ops rotate_subtract_sleep_ops_chk rotate_subtract_sleep_ops_chk_inst (
    .clk, .reset_n, .instr_valid, .instr, .wake, .wdt_tick, .acc, .status, .file_wr,
    .watchdog_counter, .wdt_prescaler, .sleeping, .osc_run, .instr_ready);

// ### test/test_rotate_subtract_sleep_ops.sv
// Testbench for the rotate, subtract and sleep execution block
`timescale 1ns/1ps
module test_rotate_subtract_sleep_ops;
    import exec_pkg::*;
    logic              clk = 1'b0;
    logic              reset_n = 1'b0;
    logic              instr_valid = 1'b0;
    instr_t            instr = '0;
    logic              wake = 1'b0;
    logic              wdt_tick = 1'b0;
    logic [DATA_W-1:0] acc;
    status_t           status;
    file_wr_t          file_wr;
    logic [WDT_W-1:0]  watchdog_counter;
    logic [PRE_W-1:0]  wdt_prescaler;
    logic              sleeping;
    logic              osc_run;
    logic              instr_ready;
    int                err_count = 0;
    int                num_checks = 0;
    always #5 clk = ~clk;
    rotate_subtract_sleep_ops rotate_subtract_sleep_ops_inst (
        .clk, .reset_n, .instr_valid, .instr, .wake, .wdt_tick, .acc, .status, .file_wr,
        .watchdog_counter, .wdt_prescaler, .sleeping, .osc_run, .instr_ready);
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    // One instruction, then acc, carry/nibble/zero and the file write are compared
    task automatic run(input op_t op, input logic d, input logic [7:0] lit, input logic [7:0] fv,
        input logic [7:0] ea, input logic [2:0] ef, input logic ew, input logic [7:0] ed);
        @(posedge clk);
        instr_valid <= 1'b1;
        instr <= '{op: op, dest: d, addr: 7'h11, literal: lit, file_value: fv};
        @(posedge clk);
        instr_valid <= 1'b0;
        #1;
        chk(acc, ea, "acc");
        chk({5'h0, status[4:2]}, {5'h0, ef}, "flags");
        chk({7'h0, file_wr.we}, {7'h0, ew}, "write");
        if (ew) begin
            chk(file_wr.data, ed, "data");
            chk({1'b0, file_wr.addr}, 8'h11, "addr");
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        #1;
        chk({3'h0, status}, 8'h03, "reset status");
        chk(acc, ACC_RESET, "reset acc");
        $display("test reset done");
        run(OP_LITERAL_MINUS_ACC, DEST_ACC, 8'h05, 8'h00, 8'h05, 3'b110, 1'b0, 8'h00);
        run(OP_ROTATE_RIGHT_VIA_CARRY, DEST_ACC, 8'h00, 8'h82, 8'hc1, 3'b010, 1'b0, 8'h00);
        run(OP_ROTATE_RIGHT_VIA_CARRY, DEST_FILE, 8'h00, 8'h03, 8'hc1, 3'b110, 1'b1, 8'h01);
        $display("test rotate done");
        run(OP_LITERAL_MINUS_ACC, DEST_ACC, 8'h10, 8'h00, 8'h4f, 3'b000, 1'b0, 8'h00);
        run(OP_LITERAL_MINUS_ACC, DEST_ACC, 8'h52, 8'h00, 8'h03, 3'b100, 1'b0, 8'h00);
        run(OP_FILE_MINUS_ACC, DEST_FILE, 8'h00, 8'h05, 8'h03, 3'b110, 1'b1, 8'h02);
        run(OP_FILE_MINUS_ACC, DEST_ACC, 8'h00, 8'h03, 8'h00, 3'b111, 1'b0, 8'h00);
        run(OP_FILE_MINUS_ACC_WITH_BORROW, DEST_ACC, 8'h00, 8'h00, 8'h00, 3'b111, 1'b0, 8'h00);
        run(OP_LITERAL_MINUS_ACC, DEST_ACC, 8'h01, 8'h00, 8'h01, 3'b110, 1'b0, 8'h00);
        run(OP_FILE_MINUS_ACC, DEST_ACC, 8'h00, 8'h00, 8'hff, 3'b000, 1'b0, 8'h00);
        run(OP_FILE_MINUS_ACC_WITH_BORROW, DEST_FILE, 8'h00, 8'h10, 8'hff, 3'b000, 1'b1, 8'h10);
        $display("test subtract done");
        // Let the watchdog move so that clearing it is visible
        @(posedge clk);
        wdt_tick <= 1'b1;
        repeat (3) @(posedge clk);
        wdt_tick <= 1'b0;
        #1;
        chk(watchdog_counter, 8'h03, "watchdog count");
        run(OP_SLEEP, DEST_ACC, 8'h00, 8'h00, 8'hff, 3'b000, 1'b0, 8'h00);
        chk(watchdog_counter, WDT_CLEAR, "watchdog");
        chk(wdt_prescaler, PRE_CLEAR, "prescaler");
        chk({3'h0, status}, 8'h02, "sleep status");
        chk({6'h0, osc_run, instr_ready}, 8'h00, "halted");
        run(OP_LITERAL_MINUS_ACC, DEST_ACC, 8'h00, 8'h00, 8'hff, 3'b000, 1'b0, 8'h00);
        @(posedge clk);
        wake <= 1'b1;
        @(posedge clk);
        wake <= 1'b0;
        #1;
        chk({6'h0, osc_run, instr_ready}, 8'h03, "running after wake");
        $display("test sleep done");
        // Reset in mid-run brings the power status bits back
        @(posedge clk);
        reset_n <= 1'b0;
        @(posedge clk);
        reset_n <= 1'b1;
        #1;
        chk({3'h0, status}, 8'h03, "status after reset");
        chk(acc, ACC_RESET, "acc after reset");
        $display("test second reset done");
        wrap_up();
    end
    // Whole run is under 100 cycles; this cuts a hang short
    initial begin
        #100000;
        err_count++;
        $display("unexpected at %0t: run did not finish", $time);
        wrap_up();
    end
endmodule
